// *** hdl/lacl_front_end.sv ***
module lacl_front_end #(
  parameter int ID_W = 8 * lacl_pkg::ID_BYTES,
  parameter int WIN  = lacl_pkg::WINDOW_DEFAULT
) (
  // Clock and reset
  input  wire logic                       clock_i,
  input  wire logic                       nrst_i,
  // Link state
  input  wire logic                       link_active_i,
  input  wire logic                       initial_activation_i,
  input  wire logic                       rf_cause_i,
  input  wire logic                       fe_upper_neg_i,
  input  wire logic [ID_W-1:0]            identity_ref_i,
  // Received frame byte stream
  input  wire logic                       rx_valid_i,
  input  wire logic                       rx_first_i,
  input  wire logic                       rx_last_i,
  input  wire logic                       rx_crc_ok_i,
  input  wire logic [7:0]                 rx_data_i,
  // Power level frame request
  input  wire logic                       pwr_req_i,
  input  wire logic                       pwr_full_i,
  // Reliable layer transmit side
  input  wire logic                       i_send_i,
  input  wire logic [lacl_pkg::SEQ_W-1:0] i_send_nr_i,
  input  wire logic                       sess_open_req_i,
  // Power level frame out
  output logic                            pwr_frame_valid_o,
  output logic [7:0]                      pwr_ctrl_o,
  output logic [7:0]                      pwr_data_o,
  output logic [7:0]                      pwr_cap_o,
  // Card capabilities
  output logic                            cap_valid_o,
  output logic [4:0]                      card_cap_o,
  output logic                            ext_bit_dur_ok_o,
  output logic                            upper_neg_en_o,
  // Identity check
  output logic                            id_done_o,
  output logic                            id_pass_o,
  output logic                            id_fail_o,
  output logic                            sess_open_o,
  // Reliable layer receive and transmit sides
  output logic                            rel_deliver_o,
  output logic                            rel_s_frame_o,
  output logic                            rel_u_frame_o,
  output logic [lacl_pkg::SEQ_W-1:0]      rel_nr_o,
  output logic [lacl_pkg::SEQ_W-1:0]      i_ctrl_ns_o,
  output logic [7:0]                      i_ctrl_o,
  output logic                            i_accepted_o,
  output logic                            can_send_o
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (ID_W < 8 || ID_W > 64 || (ID_W % 8) != 0)
  begin : g_bad_id_width
    $error("Identifier width must be whole bytes, 8 to 64 bits.");
  end

  typedef enum logic [3:0] {
    LACL_IDLE = 4'b0001,
    LACL_ACT  = 4'b0010,
    LACL_REL  = 4'b0100,
    LACL_SKIP = 4'b1000
  } lacl_state_e;

  // ----------------------------------------------------------------------
  // Frame parser
  // ----------------------------------------------------------------------
  lacl_state_e          state;
  logic [7:0]           ctrl;
  logic [7:0]           prev_byte;
  logic [ID_W-1:0]      id_shift;
  logic [ID_W+15:0]     id_window;
  logic [lacl_pkg::SEQ_W-1:0] expect_ns;
  logic                 link_q;
  logic                 activation_start;
  logic                 frame_end;
  logic                 is_sync;
  logic                 info_flag;
  logic [ID_W-1:0]      presented;
  logic                 ns_in_order;
  logic                 win_can_send;
  logic [lacl_pkg::SEQ_W-1:0] win_ns;

  assign activation_start = link_active_i && !link_q;
  assign frame_end        = rx_valid_i && rx_last_i;
  assign is_sync          = (ctrl[2:0] & lacl_pkg::ACT_KIND_MASK) == lacl_pkg::ACT_KIND_SYNC;
  assign info_flag        = ctrl[lacl_pkg::ACT_INFO_FLAG_POS];
  assign ns_in_order      = ctrl[lacl_pkg::NS_POS +: lacl_pkg::SEQ_W] == expect_ns;

  // With the capability byte appended the identifier ends one byte before the last.
  assign id_window = {id_shift, prev_byte, rx_data_i};
  assign presented = info_flag ? id_window[ID_W+7:8] : id_window[ID_W-1:0];

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      link_q <= 1'b0;
    else
      link_q <= link_active_i;
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      state <= LACL_IDLE;
    else if (!link_active_i)
      state <= LACL_IDLE;
    else if (rx_valid_i)
    begin
      case (state)
        LACL_IDLE:
        begin
          if (rx_first_i && !rx_last_i)
          begin
            if ((rx_data_i & lacl_pkg::CTRL_CLASS_MASK) == lacl_pkg::CTRL_ACT_CLASS)
              state <= LACL_ACT;
            else if ((rx_data_i & lacl_pkg::RELIABLE_BIT_MASK) != 8'h00)
              state <= LACL_REL;
            else
              state <= LACL_SKIP;
          end
        end
        default:
        begin
          if (rx_last_i)
            state <= LACL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ctrl      <= 8'h00;
      prev_byte <= 8'h00;
      id_shift  <= '0;
    end
    else if (rx_valid_i)
    begin
      if (rx_first_i)
        ctrl <= rx_data_i;
      else
      begin
        prev_byte <= rx_data_i;
        id_shift  <= ID_W'({id_shift, prev_byte});
      end
    end
  end

  // ----------------------------------------------------------------------
  // Card capabilities
  // ----------------------------------------------------------------------
  logic sync_announce_frame_end;
  logic cap_present;

  assign sync_announce_frame_end = frame_end && !rx_first_i && state == LACL_ACT && is_sync && rx_crc_ok_i;
  assign cap_present  = sync_announce_frame_end && info_flag;

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cap_valid_o <= 1'b0;
      card_cap_o  <= lacl_pkg::CAP_RESET;
    end
    else if (!link_active_i)
    begin
      cap_valid_o <= 1'b0;
      card_cap_o  <= lacl_pkg::CAP_RESET;
    end
    else if (cap_present)
    begin
      cap_valid_o <= 1'b1;
      card_cap_o  <= 5'(rx_data_i & lacl_pkg::CARD_CAP_MASK);
    end
  end

  // Extended durations are only granted from the first activation's sync frame.
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ext_bit_dur_ok_o <= 1'b0;
    else if (!link_active_i)
      ext_bit_dur_ok_o <= 1'b0;
    else if (cap_present && initial_activation_i)
      ext_bit_dur_ok_o <= rx_data_i[lacl_pkg::CAP_SHORT_BIT_POS]
                          | rx_data_i[lacl_pkg::CAP_LONG_BIT_POS];
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      upper_neg_en_o <= 1'b0;
    else if (!link_active_i)
      upper_neg_en_o <= 1'b0;
    else if (cap_present)
      upper_neg_en_o <= rx_data_i[lacl_pkg::CAP_UPPER_NEG_POS] && fe_upper_neg_i;
    else
      upper_neg_en_o <= cap_valid_o && card_cap_o[lacl_pkg::CAP_UPPER_NEG_POS] && fe_upper_neg_i;
  end

  // ----------------------------------------------------------------------
  // Identity check
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      id_done_o <= 1'b0;
      id_pass_o <= 1'b0;
      id_fail_o <= 1'b0;
    end
    else if (activation_start)
    begin
      id_done_o <= 1'b0;
      id_pass_o <= 1'b0;
      id_fail_o <= 1'b0;
    end
    else if (sync_announce_frame_end && !id_done_o)
    begin
      id_done_o <= 1'b1;
      id_pass_o <= (presented == identity_ref_i);
      id_fail_o <= (presented != identity_ref_i);
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      sess_open_o <= 1'b0;
    else if (!link_active_i)
      sess_open_o <= 1'b0;
    else if (sess_open_req_i && id_pass_o)
      sess_open_o <= 1'b1;
  end

  // ----------------------------------------------------------------------
  // Power level frame
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pwr_frame_valid_o <= 1'b0;
      pwr_ctrl_o        <= 8'h00;
      pwr_data_o        <= lacl_pkg::POWER_LOW;
      pwr_cap_o         <= 8'h00;
    end
    else
    begin
      pwr_frame_valid_o <= pwr_req_i && link_active_i;
      if (pwr_req_i)
      begin
        pwr_ctrl_o <= lacl_pkg::CTRL_ACT_CLASS | 8'(lacl_pkg::ACT_KIND_POWER);
        pwr_ctrl_o[lacl_pkg::ACT_INFO_FLAG_POS] <= cap_valid_o && card_cap_o[lacl_pkg::CAP_RX_INFO_POS];
        pwr_data_o <= pwr_full_i ? lacl_pkg::POWER_FULL : lacl_pkg::POWER_LOW;
        pwr_cap_o  <= 8'h00;
        pwr_cap_o[lacl_pkg::FE_RF_CAUSE_POS]  <= rf_cause_i;
        pwr_cap_o[lacl_pkg::FE_UPPER_NEG_POS] <= fe_upper_neg_i;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Reliable layer frame classes
  // ----------------------------------------------------------------------
  logic rel_end;
  logic is_i;
  logic is_s;
  logic is_u;

  assign rel_end = frame_end && state == LACL_REL && rx_crc_ok_i;
  assign is_i    = (ctrl & lacl_pkg::REL_TYPE_MASK) == lacl_pkg::REL_I_FRAME;
  assign is_s    = (ctrl & lacl_pkg::REL_SU_MASK) == lacl_pkg::REL_S_FRAME;
  assign is_u    = (ctrl & lacl_pkg::REL_SU_MASK) == lacl_pkg::REL_U_FRAME;

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rel_deliver_o <= 1'b0;
      rel_s_frame_o <= 1'b0;
      rel_u_frame_o <= 1'b0;
      rel_nr_o      <= '0;
      expect_ns     <= '0;
    end
    else
    begin
      rel_deliver_o <= rel_end && is_i && ns_in_order;
      rel_s_frame_o <= rel_end && is_s;
      rel_u_frame_o <= rel_end && is_u;
      if (!link_active_i)
        expect_ns <= '0;
      else if (rel_end && is_i && ns_in_order)
        expect_ns <= expect_ns + 1'b1;
      if (rel_end && (is_i || is_s))
        rel_nr_o <= ctrl[lacl_pkg::SEQ_W-1:0];
    end
  end

  // Acknowledgements from received I and S frames release window slots.
  lacl_seq_window #(
    .WIN_SIZE (WIN)
  ) u_window (
    .clock_i   (clock_i),
    .nrst_i    (nrst_i),
    .restart_i (!link_active_i),
    .sent_i    (i_send_i),
    .ack_i     (rel_end && (is_i || is_s)),
    .ack_nr_i  (ctrl[lacl_pkg::SEQ_W-1:0]),
    .next_ns_o (win_ns),
    .can_send_o(win_can_send)
  );

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      i_ctrl_o     <= 8'h00;
      i_ctrl_ns_o  <= '0;
      i_accepted_o <= 1'b0;
      can_send_o   <= 1'b0;
    end
    else
    begin
      can_send_o   <= win_can_send;
      i_accepted_o <= i_send_i && win_can_send;
      if (i_send_i && win_can_send)
      begin
        i_ctrl_ns_o <= win_ns;
        i_ctrl_o    <= lacl_pkg::REL_I_FRAME | 8'({win_ns, i_send_nr_i});
      end
    end
  end

endmodule // lacl_front_end

// *** hdl/lacl_seq_window.sv ***
// Send-side sliding window: counts unacknowledged information frames.
module lacl_seq_window #(
  parameter int WIN_SIZE = lacl_pkg::WINDOW_DEFAULT
) (
  // Clock and reset
  input  wire logic                     clock_i,
  input  wire logic                     nrst_i,
  // Control
  input  wire logic                     restart_i,
  input  wire logic                     sent_i,
  input  wire logic                     ack_i,
  input  wire logic [lacl_pkg::SEQ_W-1:0] ack_nr_i,
  // Status
  output logic      [lacl_pkg::SEQ_W-1:0] next_ns_o,
  output logic                          can_send_o
);

  if (WIN_SIZE < 1 || WIN_SIZE > 7)
  begin : g_bad_window
    $error("Window size must be between 1 and 7.");
  end

  logic [lacl_pkg::SEQ_W-1:0] oldest;
  logic [lacl_pkg::SEQ_W-1:0] in_flight;

  assign in_flight  = next_ns_o - oldest;
  assign can_send_o = (in_flight < lacl_pkg::SEQ_W'(WIN_SIZE));

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      next_ns_o <= '0;
    else if (restart_i)
      next_ns_o <= '0;
    else if (sent_i && can_send_o)
      next_ns_o <= next_ns_o + 1'b1;
  end

  // An acknowledgement outside the outstanding range is ignored.
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      oldest <= '0;
    else if (restart_i)
      oldest <= '0;
    else if (ack_i && ((ack_nr_i - oldest) <= in_flight))
      oldest <= ack_nr_i;
  end

endmodule // lacl_seq_window

// *** include/lacl_pkg.sv ***
package lacl_pkg;

  // ----------------------------------------------------------------------
  // Frame control field classes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_CLASS_MASK   = 8'hE0;
  localparam logic [7:0] CTRL_ACT_CLASS    = 8'h60;
  localparam logic [7:0] CTRL_SESS_CLASS   = 8'h40;
  localparam logic [7:0] RELIABLE_BIT_MASK = 8'h80;
  localparam logic [7:0] REL_TYPE_MASK     = 8'hC0;
  localparam logic [7:0] REL_I_FRAME       = 8'h80;
  localparam logic [7:0] REL_SU_MASK       = 8'hE0;
  localparam logic [7:0] REL_S_FRAME       = 8'hC0;
  localparam logic [7:0] REL_U_FRAME       = 8'hE0;
  localparam int         NS_POS            = 3;
  localparam int         SEQ_W             = 3;

  // ----------------------------------------------------------------------
  // Activation layer type field
  // ----------------------------------------------------------------------
  localparam int         ACT_INFO_FLAG_POS = 4;
  localparam logic [2:0] ACT_KIND_MASK     = 3'h7;
  localparam logic [2:0] ACT_KIND_SYNC     = 3'h2;
  localparam logic [2:0] ACT_KIND_POWER    = 3'h1;

  // ----------------------------------------------------------------------
  // Capability byte fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] CARD_CAP_MASK     = 8'h1F;
  localparam int         CAP_UPPER_NEG_POS = 4;
  localparam int         CAP_RX_INFO_POS   = 3;
  localparam int         CAP_EXT_RESUME    = 2;
  localparam int         CAP_SHORT_BIT_POS = 1;
  localparam int         CAP_LONG_BIT_POS  = 0;
  localparam int         FE_RF_CAUSE_POS   = 0;
  localparam int         FE_UPPER_NEG_POS  = 1;

  // ----------------------------------------------------------------------
  // Power level data values, reset values and default sizes
  // ----------------------------------------------------------------------
  localparam logic [7:0] POWER_LOW         = 8'h00;
  localparam logic [7:0] POWER_FULL        = 8'h01;
  localparam logic [4:0] CAP_RESET         = 5'h00;
  localparam int         ID_BYTES          = 2;
  localparam int         WINDOW_DEFAULT    = 4;

endpackage

// *** tb/lacl_card_model.sv ***
module lacl_card_model (
  // Clock
  input  wire logic clock_i,
  // Byte stream toward the front-end
  output logic       rx_valid_o,
  output logic       rx_first_o,
  output logic       rx_last_o,
  output logic       rx_crc_ok_o,
  output logic [7:0] rx_data_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    rx_valid_o = 1'b0;
    rx_first_o = 1'b0;
    rx_last_o = 1'b0;
    rx_crc_ok_o = 1'b0;
    rx_data_o = 8'h5A;
  end

  // Between frames the data line shows the inverse of the last byte, so a stale byte is never seen as valid.
  task automatic send(input int n, input logic [31:0] b, input logic ok);
    for (int i = n - 1; i >= 0; i--)
    begin
      @(negedge clock_i);
      rx_valid_o = 1'b1;
      rx_first_o = (i == n - 1);
      rx_last_o = (i == 0);
      rx_crc_ok_o = ok;
      rx_data_o = b[8*i +: 8];
    end
    @(negedge clock_i);
    rx_valid_o = 1'b0;
    rx_last_o = 1'b0;
    rx_crc_ok_o = 1'b0;
    rx_data_o = ~rx_data_o;
  endtask

  task automatic sync(input logic [15:0] id, input logic [4:0] f, input logic [2:0] rfu, input logic app);
    if (app)
      send(4, {8'h72, id, rfu, f}, 1'b1);
    else
      send(3, {8'h00, 8'h62, id}, 1'b1);
  endtask
endmodule // lacl_card_model

// *** tb/lacl_front_end_bench.sv ***
module lacl_front_end_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock_i = 1'b0, nrst_i = 1'b0, link_active_i = 1'b0, initial_activation_i = 1'b0;
  logic        rf_cause_i = 1'b0, fe_upper_neg_i = 1'b0, pwr_req_i = 1'b0, pwr_full_i = 1'b0;
  logic        i_send_i = 1'b0, sess_open_req_i = 1'b0, rx_valid_i, rx_first_i, rx_last_i, rx_crc_ok_i;
  logic        pwr_frame_valid_o, cap_valid_o, ext_bit_dur_ok_o, upper_neg_en_o, id_done_o, id_pass_o;
  logic        id_fail_o, sess_open_o, rel_deliver_o, rel_s_frame_o, rel_u_frame_o, i_accepted_o, can_send_o;
  logic [2:0]  i_send_nr_i = 3'h0, rel_nr_o, i_ctrl_ns_o;
  logic [4:0]  card_cap_o;
  logic [7:0]  rx_data_i, pwr_ctrl_o, pwr_data_o, pwr_cap_o, i_ctrl_o;
  logic [15:0] identity_ref_i = 16'h0000;
  logic [31:0] notes[$];
  logic        prev_done = 1'b0;
  int          errors = 0, cmp_count = 0;
  integer      seed = 32'h8C136F06;

  always #2.5 clock_i = ~clock_i;

  lacl_front_end i_dut (.*);
  lacl_card_model i_card (.clock_i(clock_i), .rx_valid_o(rx_valid_i), .rx_first_o(rx_first_i),
                          .rx_last_o(rx_last_i), .rx_crc_ok_o(rx_crc_ok_i), .rx_data_o(rx_data_i));

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic pop(input logic [31:0] seen);
    if (notes.size() == 0)
      check("unexpected result", seen, 32'h00000000);
    else
      check("result", seen, notes.pop_front());
  endtask

  // ----------------------------------------------------------------------
  // Result monitor
  // ----------------------------------------------------------------------
  always @(negedge clock_i)
  begin
    if (pwr_frame_valid_o)
      pop({8'h01, pwr_ctrl_o, pwr_data_o, pwr_cap_o});
    if (id_done_o && !prev_done)
      pop({8'h02, 14'h0000, cap_valid_o, card_cap_o, ext_bit_dur_ok_o, upper_neg_en_o, id_pass_o, id_fail_o});
    if (rel_deliver_o || rel_s_frame_o || rel_u_frame_o)
      pop({8'h03, 18'h00000, rel_deliver_o, rel_s_frame_o, rel_u_frame_o, rel_u_frame_o ? 3'h0 : rel_nr_o});
    if (i_accepted_o)
      pop({8'h04, 13'h0000, i_ctrl_ns_o, i_ctrl_o});
    prev_done = id_done_o;
  end

  function automatic logic [31:0] id_note(input logic cv, input logic [4:0] c, input logic ext,
                                          input logic un, input logic ok);
    return {8'h02, 14'h0000, cv, c, ext, un, ok, !ok};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  task automatic pulse(ref logic s);
    @(negedge clock_i);
    s = 1'b1;
    @(negedge clock_i);
    s = 1'b0;
  endtask

  initial
  begin
    #20000;
    errors++;
    $display("watchdog expired");
    summarize();
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial
  begin : main
    logic [4:0]  f;
    logic        app;
    logic [11:0] nsl;
    nsl = {3'h1, 3'h2, 3'h1, 3'h0};
    identity_ref_i = 16'($random(seed));
    tick(3);
    nrst_i = 1'b1;
    // First activation has capabilities, the second a wrong identifier, the third upper negotiation at both ends.
    for (int a = 0; a < 3; a++)
    begin
      f = 5'($random(seed));
      f[4] = a[1];
      f[3] = (a == 0);
      f[1:0] = (a == 0) ? 2'b10 : 2'b01;
      app = (a != 1);
      fe_upper_neg_i = a[1];
      initial_activation_i = (a == 0);
      link_active_i = 1'b1;
      tick(2);
      notes.push_back(id_note(app, app ? f : 5'h00, a == 0, app & a[1], app));
      i_card.sync(app ? identity_ref_i : identity_ref_i ^ 16'h0001, f, (a == 0) ? 3'h5 : 3'h0, app);
      tick(2);
      for (int p = 0; p < 2; p++)
      begin
        rf_cause_i = 1'($random(seed));
        pwr_full_i = p[0];
        notes.push_back({8'h01, 3'h3, app & f[3], 4'h1, 7'h00, p[0], 6'h00, a[1], rf_cause_i});
        pulse(pwr_req_i);
      end
      pulse(sess_open_req_i);
      tick(1);
      check("session open", sess_open_o, app);
      link_active_i = 1'b0;
      tick(2);
      check("stored capabilities", {cap_valid_o, card_cap_o}, 6'h00);
      $display("activation test %0d finished", a);
    end
    link_active_i = 1'b1;
    tick(2);
    notes.push_back(id_note(1'b0, 5'h00, 1'b0, 1'b0, 1'b1));
    i_card.sync(identity_ref_i, 5'h00, 3'h0, 1'b0);
    tick(2);
    // Good frame, corrupted frame, frame out of order, then the missing frame.
    for (int k = 0; k < 4; k++)
    begin
      if (k == 0 || k == 3)
        notes.push_back({8'h03, 18'h00000, 3'h4, 3'h0});
      i_card.send(2, {16'h0000, 2'b10, nsl[3*k +: 3], 3'h0, 8'($random(seed))}, k != 1);
    end
    notes.push_back({8'h03, 18'h00000, 3'h1, 3'h0});
    i_card.send(2, {16'h0000, 8'hF9, 8'h00}, 1'b1);
    for (int k = 0; k < 5; k++)
    begin
      i_send_nr_i = 3'($random(seed));
      if (k < 4)
        notes.push_back({8'h04, 13'h0000, k[2:0], 2'b10, k[2:0], i_send_nr_i});
      pulse(i_send_i);
      tick(1);
    end
    check("send allowed", can_send_o, 1'b0);
    notes.push_back({8'h03, 18'h00000, 3'h2, 3'h2});
    i_card.send(2, {16'h0000, 8'hC2, 8'h00}, 1'b1);
    tick(2);
    check("send allowed", can_send_o, 1'b1);
    notes.push_back({8'h04, 13'h0000, 3'h4, 2'b10, 3'h4, i_send_nr_i});
    pulse(i_send_i);
    tick(2);
    check("results left", 32'(notes.size()), 32'h00000000);
    $display("link layer test finished");
    summarize();
  end
endmodule // lacl_front_end_bench

bind lacl_front_end lacl_properties i_props (.*);

// *** tb/lacl_properties.sv ***
module lacl_properties (
  // Clock and reset
  input wire logic                       clock_i,
  input wire logic                       nrst_i,
  // Front-end inputs
  input wire logic                       link_active_i,
  input wire logic                       rf_cause_i,
  input wire logic                       fe_upper_neg_i,
  input wire logic                       pwr_req_i,
  input wire logic                       pwr_full_i,
  input wire logic                       i_send_i,
  input wire logic [lacl_pkg::SEQ_W-1:0] i_send_nr_i,
  // Front-end outputs
  input wire logic                       pwr_frame_valid_o,
  input wire logic [7:0]                 pwr_ctrl_o,
  input wire logic [7:0]                 pwr_data_o,
  input wire logic [7:0]                 pwr_cap_o,
  input wire logic                       cap_valid_o,
  input wire logic [4:0]                 card_cap_o,
  input wire logic                       ext_bit_dur_ok_o,
  input wire logic                       upper_neg_en_o,
  input wire logic                       id_done_o,
  input wire logic                       id_pass_o,
  input wire logic                       id_fail_o,
  input wire logic                       sess_open_o,
  input wire logic [7:0]                 i_ctrl_o,
  input wire logic                       i_accepted_o,
  input wire logic                       can_send_o
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  // ----------------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------------
  sequence s_steady_link;
    link_active_i && $past(link_active_i) ##1 link_active_i;
  endsequence

  sequence s_send_ok;
    i_send_i && can_send_o;
  endsequence

  AST_PWR_DATA: assert property (
    pwr_req_i |=> pwr_frame_valid_o && pwr_data_o == {7'h00, $past(pwr_full_i)})
    else $error("power data byte wrong");
  AST_PWR_CAP: assert property (
    pwr_req_i |=> pwr_cap_o == {6'h00, $past(fe_upper_neg_i), $past(rf_cause_i)})
    else $error("power capability byte wrong");
  AST_PWR_CTRL: assert property (
    pwr_frame_valid_o |-> pwr_ctrl_o[7:5] == 3'h3 && pwr_ctrl_o[2:0] == lacl_pkg::ACT_KIND_POWER
      && (card_cap_o[3] || !pwr_ctrl_o[4]))
    else $error("power control byte wrong");
  AST_SESS: assert property (
    sess_open_o |-> id_pass_o && !id_fail_o)
    else $error("session open without identity pass");
  AST_ID_ONE: assert property (
    id_done_o |-> id_pass_o != id_fail_o)
    else $error("identity result not exclusive");
  AST_ID_HOLD: assert property (
    id_done_o ##0 s_steady_link |-> $stable({id_done_o, id_pass_o, id_fail_o}))
    else $error("identity result changed within activation");
  AST_CAP_CLR: assert property (
    $fell(link_active_i) |=> !cap_valid_o && card_cap_o == 5'h00)
    else $error("capabilities kept after deactivation");
  AST_EXT: assert property (
    ext_bit_dur_ok_o |-> cap_valid_o && (card_cap_o[1] || card_cap_o[0]))
    else $error("extended durations without advertisement");
  AST_UPNEG: assert property (
    upper_neg_en_o |-> cap_valid_o && card_cap_o[4] && $past(fe_upper_neg_i))
    else $error("negotiation enabled without both ends");
  AST_I_ACC: assert property (
    s_send_ok |=> i_accepted_o && i_ctrl_o[7:6] == 2'b10 && i_ctrl_o[2:0] == $past(i_send_nr_i))
    else $error("information frame not built");
  AST_REFUSE: assert property (
    i_send_i && !can_send_o |=> !i_accepted_o)
    else $error("send accepted with window full");
endmodule // lacl_properties
